//--- verilog/zapt_pkg.sv
// package: register map, field layout and timing constants for zone phase timing
package zapt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ZAPT_ADDR_TIMING = 4'h0;
  localparam logic [3:0] ZAPT_ADDR_CLKCFG = 4'h4;
  localparam logic [3:0] ZAPT_ADDR_STATUS = 4'h8;

  // ----------------------------------------------------------------
  // field positions of zone_timing_config
  // ----------------------------------------------------------------
  localparam int ZAPT_DBL_POS = 22;
  localparam int ZAPT_RDLEAD_POS = 12;
  localparam int ZAPT_RDACT_POS = 9;
  localparam int ZAPT_RDTRAIL_POS = 7;
  localparam int ZAPT_WRLEAD_POS = 5;
  localparam int ZAPT_WRACT_POS = 2;
  localparam int ZAPT_WRTRAIL_POS = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ZAPT_TIMING_RST = 32'h0000_3fff;
  localparam logic [2:0] ZAPT_CLKDIV_RST = 3'h1;

  // ----------------------------------------------------------------
  // phase clock divider codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ZAPT_CLKDIV_1 = 3'h0;
  localparam logic [2:0] ZAPT_CLKDIV_2 = 3'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [3:0] ZAPT_ACTIVE_BASE = 4'h1;
  localparam int ZAPT_CNT_W = 5;

  typedef enum logic [1:0] {
    ZAPT_IDLE = 2'b00,
    ZAPT_LEAD = 2'b01,
    ZAPT_ACTIVE = 2'b11,
    ZAPT_TRAIL = 2'b10
  } zapt_phase_type;

endpackage : zapt_pkg

//--- verilog/zapt_decode.sv
// decoder from timing fields to phase cycle counts
`timescale 1ns/1ns
module zapt_decode
  import zapt_pkg::*;
(
  input wire logic [31:0] cfg,
  input wire logic is_write,
  output logic [ZAPT_CNT_W-1:0] lead_cycles,
  output logic [ZAPT_CNT_W-1:0] active_cycles,
  output logic [ZAPT_CNT_W-1:0] trail_cycles,
  output logic lead_invalid
);

  logic dbl;
  logic [1:0] lead_code;
  logic [2:0] wait_code;
  logic [1:0] trail_code;
  logic [3:0] wait_cnt;

  always_comb begin
    dbl = cfg[ZAPT_DBL_POS];
    lead_code = is_write ? cfg[ZAPT_WRLEAD_POS +: 2] : cfg[ZAPT_RDLEAD_POS +: 2];
    wait_code = is_write ? cfg[ZAPT_WRACT_POS +: 3] : cfg[ZAPT_RDACT_POS +: 3];
    trail_code = is_write ? cfg[ZAPT_WRTRAIL_POS +: 2] : cfg[ZAPT_RDTRAIL_POS +: 2];
    lead_invalid = (lead_code == 2'h0);
    // code zero stays zero when doubled
    wait_cnt = dbl ? {wait_code, 1'b0} : {1'b0, wait_code};
    lead_cycles = dbl ? {2'h0, lead_code, 1'b0} : {3'h0, lead_code};
    active_cycles = {1'b0, wait_cnt} + {1'b0, ZAPT_ACTIVE_BASE};
    trail_cycles = dbl ? {2'h0, trail_code, 1'b0} : {3'h0, trail_code};
  end

endmodule : zapt_decode

//--- verilog/zapt_top.sv
// zone access phase timing: config registers and lead/active/trail sequencer
//
// Overview of operation
// - read wait codes 110/111 add 6/7 active cycles, or 12/14 doubled.
// - read trail field gives 0..3 cycles, twice that doubled.
// - write lead codes 01..11 give 1..3 cycles, 2/4/6 doubled; 00 invalid.
// - write wait field adds 0..7 active cycles, or 0..14 even doubled.
// - write active phase is one base cycle plus decoded wait count.
// - write wait code 000 adds nothing, doubled or not.
// - write trail 00 gives zero; 01..11 give 1..3, or 2/4/6 doubled.
// - doubling select doubles every lead, wait and trail count.
// - read lead codes 01..11 give 1..3 cycles, 2/4/6 doubled; 00 invalid.
// - phase clock is system clock or half of it; other codes reserved.
`timescale 1ns/1ns
module zapt_top
  import zapt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic start,
  input wire logic start_write,
  output logic busy,
  output logic lead_phase,
  output logic active_phase,
  output logic trail_phase,
  output logic done,
  output logic error
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] timing_ff;
  logic [2:0] clkdiv_ff;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic done_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      timing_ff <= ZAPT_TIMING_RST;
    end else if (wr_en && addr == ZAPT_ADDR_TIMING) begin
      timing_ff <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clkdiv_ff <= ZAPT_CLKDIV_RST;
    end else if (wr_en && addr == ZAPT_ADDR_CLKCFG) begin
      clkdiv_ff <= wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // phase clock enable
  // ----------------------------------------------------------------
  logic tick_ff;
  logic tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= ~tick_ff;
    end
  end

  // reserved divider codes fall back to half rate, the slower safe choice
  assign tick = (clkdiv_ff == ZAPT_CLKDIV_1) ? 1'b1 : tick_ff;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  zapt_phase_type state_ff;
  zapt_phase_type nxt_state;
  logic [ZAPT_CNT_W-1:0] cnt_ff;
  logic [ZAPT_CNT_W-1:0] nxt_cnt;
  logic wr_ff;
  logic [ZAPT_CNT_W-1:0] lead_c;
  logic [ZAPT_CNT_W-1:0] act_c;
  logic [ZAPT_CNT_W-1:0] trail_c;
  logic lead_bad;
  logic [ZAPT_CNT_W-1:0] s_lead;
  logic [ZAPT_CNT_W-1:0] s_act;
  logic [ZAPT_CNT_W-1:0] s_trail;
  logic s_bad;

  // live decode for the access being launched, latched decode while running
  zapt_decode u_decode (
    .cfg(timing_ff),
    .is_write((state_ff == ZAPT_IDLE) ? start_write : wr_ff),
    .lead_cycles(lead_c),
    .active_cycles(act_c),
    .trail_cycles(trail_c),
    .lead_invalid(lead_bad)
  );

  logic [ZAPT_CNT_W-1:0] act_ff;
  logic [ZAPT_CNT_W-1:0] trail_ff;

  assign s_lead = lead_c;
  assign s_act = act_c;
  assign s_trail = trail_c;
  assign s_bad = lead_bad;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= 1'b0;
      act_ff <= '0;
      trail_ff <= '0;
    end else if (state_ff == ZAPT_IDLE && start) begin
      wr_ff <= start_write;
      act_ff <= s_act;
      trail_ff <= s_trail;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      ZAPT_IDLE: begin
        if (start && !s_bad) begin
          nxt_state = ZAPT_LEAD;
          nxt_cnt = s_lead;
        end
      end
      ZAPT_LEAD: begin
        if (tick) begin
          if (cnt_ff <= 5'h1) begin
            nxt_state = ZAPT_ACTIVE;
            nxt_cnt = act_ff;
          end else begin
            nxt_cnt = cnt_ff - 5'h1;
          end
        end
      end
      ZAPT_ACTIVE: begin
        if (tick) begin
          if (cnt_ff <= 5'h1) begin
            nxt_state = (trail_ff == '0) ? ZAPT_IDLE : ZAPT_TRAIL;
            nxt_cnt = trail_ff;
          end else begin
            nxt_cnt = cnt_ff - 5'h1;
          end
        end
      end
      ZAPT_TRAIL: begin
        if (tick) begin
          if (cnt_ff <= 5'h1) begin
            nxt_state = ZAPT_IDLE;
            nxt_cnt = '0;
          end else begin
            nxt_cnt = cnt_ff - 5'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ZAPT_IDLE;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // status and outputs
  // ----------------------------------------------------------------
  logic finishing;
  assign finishing = (state_ff != ZAPT_IDLE) && (nxt_state == ZAPT_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= finishing;
    end
  end

  // invalid lead refuses the access; sticky until status read, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      err_ff <= 1'b0;
    end else if (state_ff == ZAPT_IDLE && start && s_bad) begin
      err_ff <= 1'b1;
    end else if (rd_en && addr == ZAPT_ADDR_STATUS) begin
      err_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (rd_en) begin
      unique case (addr)
        ZAPT_ADDR_TIMING: rdata_ff <= timing_ff;
        ZAPT_ADDR_CLKCFG: rdata_ff <= {29'h0, clkdiv_ff};
        ZAPT_ADDR_STATUS: rdata_ff <= {28'h0, err_ff, state_ff, (state_ff != ZAPT_IDLE)};
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // phase outputs
  // ----------------------------------------------------------------
  // taken from the next state, so the pins line up with state_ff
  // yet leave the block straight from a flop
  logic busy_ff;
  logic lead_out_ff;
  logic active_out_ff;
  logic trail_out_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != ZAPT_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lead_out_ff <= 1'b0;
    end else begin
      lead_out_ff <= (nxt_state == ZAPT_LEAD);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_out_ff <= 1'b0;
    end else begin
      active_out_ff <= (nxt_state == ZAPT_ACTIVE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trail_out_ff <= 1'b0;
    end else begin
      trail_out_ff <= (nxt_state == ZAPT_TRAIL);
    end
  end

  assign rdata = rdata_ff;
  assign busy = busy_ff;
  assign lead_phase = lead_out_ff;
  assign active_phase = active_out_ff;
  assign trail_phase = trail_out_ff;
  assign done = done_ff;
  assign error = err_ff;

endmodule : zapt_top

//--- test/zapt_top_asserts.sv
// checker: phase sequencing and phase length bounds of the zone timing block
`timescale 1ns/1ns
module zapt_top_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic busy,
  input wire logic lead_phase,
  input wire logic active_phase,
  input wire logic trail_phase,
  input wire logic done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_phase_one_hot:
    assert property (busy |-> $onehot({lead_phase, active_phase, trail_phase})) else $error("phases not one-hot");
  a_idle_no_phase:
    assert property (!busy |-> !(lead_phase || active_phase || trail_phase)) else $error("phase while idle");
  a_busy_lead_first:
    assert property ($rose(busy) |-> lead_phase) else $error("access not opened by lead");
  a_lead_then_active:
    assert property ($fell(lead_phase) && busy |-> active_phase) else $error("lead not followed by active");
  a_active_then_trail:
    assert property ($fell(active_phase) |-> trail_phase || done) else $error("active not followed by trail");
  a_trail_then_done:
    assert property ($fell(trail_phase) |-> done && !busy) else $error("trail not followed by done");
  a_lead_bounded:
    assert property (lead_phase |-> ##[1:13] !lead_phase) else $error("lead too long");
  a_active_bounded:
    assert property (active_phase |-> ##[1:31] !active_phase) else $error("active too long");
  a_trail_bounded:
    assert property (trail_phase |-> ##[1:13] !trail_phase) else $error("trail too long");
  a_done_one_cycle:
    assert property (done |=> !done) else $error("done longer than one cycle");
endmodule : zapt_top_asserts

bind zapt_top zapt_top_asserts u_zapt_top_asserts (.clk(clk), .rst(rst), .busy(busy), .lead_phase(lead_phase),
  .active_phase(active_phase), .trail_phase(trail_phase), .done(done));

//--- test/zapt_bus_model.sv
// far-side model: measures the lead, active and trail lengths seen on the bus
`timescale 1ns/1ns
module zapt_bus_model (
  input wire logic clk,
  input wire logic lead_phase,
  input wire logic active_phase,
  input wire logic trail_phase,
  output logic [7:0] lead_n,
  output logic [7:0] act_n,
  output logic [7:0] trail_n
);
  logic lead_ff;
  // counts restart at the first lead cycle so each access is measured alone
  always_ff @(posedge clk) begin
    lead_ff <= lead_phase;
    if (lead_phase && !lead_ff) begin
      lead_n <= 8'h1;
      act_n <= 8'h0;
      trail_n <= 8'h0;
    end else begin
      lead_n <= lead_n + {7'h0, lead_phase};
      act_n <= act_n + {7'h0, active_phase};
      trail_n <= trail_n + {7'h0, trail_phase};
    end
  end
endmodule : zapt_bus_model

//--- test/zapt_top_tb.sv
// testbench: register access and phase length checks for zone timing
`timescale 1ns/1ns
module zapt_top_tb;
  import zapt_pkg::*;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h", $time, a); end end
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, start = 0, start_write = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic busy, lead_phase, active_phase, trail_phase, done, error;
  logic [7:0] lead_n, act_n, trail_n;
  int errors = 0, cmp_count = 0;
  logic [31:0] cfg_t [5] = '{32'h0000_3d20, 32'h0040_1fa0, 32'h0040_107c, 32'h0040_1021, 32'h0000_1057};
  logic [23:0] exp_t [5] = '{24'h030702, 24'h020f06, 24'h060f00, 24'h020102, 24'h020603};
  logic [4:0] wr_t = 5'b11100;
  always #4 clk = ~clk;
  zapt_top u_zapt_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .start(start), .start_write(start_write), .busy(busy), .lead_phase(lead_phase),
    .active_phase(active_phase), .trail_phase(trail_phase), .done(done), .error(error));
  zapt_bus_model u_zapt_bus_model (.clk(clk), .lead_phase(lead_phase), .active_phase(active_phase),
    .trail_phase(trail_phase), .lead_n(lead_n), .act_n(act_n), .trail_n(trail_n));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // bounded wait: a refused access never raises done
  task automatic acc(input logic w);
    @(posedge clk);
    start <= 1'b1;
    start_write <= w;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk);
  endtask : acc
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(ZAPT_ADDR_TIMING, v);
    `CHK(v, ZAPT_TIMING_RST)
    rd(ZAPT_ADDR_CLKCFG, v);
    `CHK(v[2:0], ZAPT_CLKDIV_RST)
    rd(4'hc, v);
    `CHK(v, 32'h0)
    wr(ZAPT_ADDR_CLKCFG, {29'h0, ZAPT_CLKDIV_1});
    rd(ZAPT_ADDR_CLKCFG, v);
    `CHK(v[2:0], ZAPT_CLKDIV_1)
    $display("test regs done");
    for (int t = 0; t < 5; t++) begin
      wr(ZAPT_ADDR_TIMING, cfg_t[t]);
      acc(wr_t[t]);
      `CHK(done, 1'b1)
      `CHK({lead_n, act_n, trail_n}, exp_t[t])
      $display("test access %0d done", t);
    end
    wr(ZAPT_ADDR_TIMING, 32'h0);
    acc(1'b0);
    `CHK({error, busy, done}, 3'b100)
    rd(ZAPT_ADDR_STATUS, v);
    `CHK(v[3], 1'b1)
    rd(ZAPT_ADDR_STATUS, v);
    `CHK(v[3], 1'b0)
    acc(1'b1);
    `CHK({error, busy, done}, 3'b100)
    $display("test invalid lead done");
    wr(ZAPT_ADDR_CLKCFG, {29'h0, ZAPT_CLKDIV_2});
    wr(ZAPT_ADDR_TIMING, cfg_t[1]);
    acc(1'b0);
    `CHK(done, 1'b1)
    `CHK({act_n, trail_n}, 16'h1e0c)
    `CHK(lead_n == 8'h3 || lead_n == 8'h4, 1'b1)
    $display("test half rate done");
    @(posedge clk);
    start <= 1'b1;
    start_write <= 1'b0;
    @(posedge clk);
    start <= 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK({busy, lead_phase, active_phase, trail_phase, done, error}, 6'h0)
    rd(ZAPT_ADDR_CLKCFG, v);
    `CHK(v[2:0], ZAPT_CLKDIV_RST)
    $display("test mid run reset done");
    close_out;
  end
  initial begin
    #40000;
    errors++;
    close_out;
  end
endmodule : zapt_top_tb
